/* File: rmc_dp_model.sv */
// Datapath partner model: turns a bench request into an event strobe.
// Assumes requests change just after a rising edge of core_clk.
`default_nettype none
module rmc_dp_model (
   input  wire logic        core_clk, // System clock
   input  wire logic        fire,     // Raise one event at next edge
   input  wire logic [3:0]  idx,      // Which event bit to raise
   output logic      [11:0] evPulse   // Event strobes into the block
);
   timeunit 1ns;
   timeprecision 1ns;
   // ====================================================
   // Strobe lasts one cycle per cycle of fire, and holds its flag set against a clear in that cycle
   always_ff @(posedge core_clk) begin
      evPulse <= fire ? 12'h001 << idx : 12'h000;
   end
endmodule
`default_nettype wire

/* File: rmc_mac_ctl.sv */
// MAC control and status block: register file, thresholds, ring choice,
// frame policy checks and event flags.
// Assumes one AHB-Lite master on core_clk; datapath events arrive on core_clk.
//
// Local design decision: the AHB-Lite interface to the registers.
`default_nettype none
// Overview of operation
// - TX capacity code bits 29:27, 0..4 give 2K..32K, 5..7 reserved.
// - RX capacity code bits 26:24, same encoding.
// - Start send at threshold times 64 bytes or one whole frame queued.
// - Zero send threshold waits for a whole frame.
// - Receive DMA starts at threshold or whole frame; zero waits.
// - Serve urgent ring while frames remain and its count is below quota or no regular frame waits.
// - Quota of zero behaves like quota of one.
// - Switch to urgent ring on frame end, regular quota, or none left.
// - Control bit 31 holds soft reset 175 cycles, then self-clears.
// - Bit 19 speed; bits 19, 9, 6 survive soft reset.
// - Oversize limit 9216/9220 with jumbo, else 1518/1522.
// - Short accept keeps frames under 64 bytes but at least 10.
// - Filter: broadcast, all group, hashed group, promiscuous bits.
// - Bit 8 full duplex; bit 7 receive while sending in half.
// - Bit 10 appends FCS; bit 4 strips VLAN tag.
// - Bits 3..0 MAC and DMA enables; bit 5 urgent ring enable.
// - Status bits 11..0 set on events, cleared by writing one.
// - Test bits 20 and 19 put poll and irq timers in test mode.
// - Feature register shows real capacities at 5:3 and 2:0.
module rmc_mac_ctl (
   input  wire logic                core_clk,      // System clock
   input  wire logic                srst,          // Sync reset, high
   input  wire logic                clkEn,         // Freezes state when low
   input  wire logic                hsel,          // AHB select
   input  wire logic [31:0]         haddr,         // AHB address
   input  wire logic [1:0]          htrans,        // AHB transfer type
   input  wire logic                hwrite,        // AHB write
   input  wire logic [2:0]          hsize,         // AHB size
   input  wire logic [31:0]         hwdata,        // AHB write data
   input  wire logic                hready,        // AHB bus ready
   output logic      [31:0]         hrdata,        // AHB read data
   output logic                     hreadyout,     // AHB slave ready
   output logic                     hresp,         // AHB response
   input  wire logic [rmc_pkg::EV_BITS-1:0] evPulse, // Datapath event strobes
   input  wire logic [15:0]         txQueuedBytes, // Bytes queued for send
   input  wire logic                txFrameQueued, // Whole frame queued
   input  wire logic [15:0]         rxBufBytes,    // Bytes buffered received
   input  wire logic                rxFrameBuffered, // Whole frame buffered
   input  wire logic                urgentPending, // Urgent ring has frames
   input  wire logic                regularPending, // Regular ring has frames
   input  wire logic                frameMoved,    // DMA finished a frame
   input  wire logic [15:0]         rxFrameLen,    // Length of checked frame
   input  wire logic                rxTagged,      // Checked frame has VLAN
   input  wire logic                rxBroadcast,   // Destination broadcast
   input  wire logic                rxGroup,       // Destination multicast
   input  wire logic                rxHashHit,     // Hash filter matched
   input  wire logic                rxUnicastHit,  // Own address matched
   input  wire logic                sending,       // Transmit in progress
   output logic                     sendStart,     // Permit send to network
   output logic                     drainStart,    // Permit RX DMA move
   output logic                     urgentSelect,  // Serve urgent ring
   output logic                     rxTooLong,     // Frame flagged oversize
   output logic                     rxLengthKeep,  // Frame length acceptable
   output logic                     rxAddrAccept,  // Address filter passes
   output logic                     rxAllowed,     // Reception permitted
   output logic                     macInReset,    // Soft reset active
   output rmc_pkg::rmc_ctl_t        ctl,           // Decoded control bits
   output logic      [2:0]          txCapCode,     // TX capacity code
   output logic      [2:0]          rxCapCode,     // RX capacity code
   output logic      [13:0]         rxDescBufLen,  // RX buffer length
   output logic                     pollTimerTest, // Poll timer test mode
   output logic                     irqTimerTest   // Irq timer test mode
);
   localparam int EV_W = rmc_pkg::EV_BITS;

   // ==========================================================
   // Bus address phase capture
   logic        wrPend_reg;
   logic        rdPend_reg;
   logic [7:0]  addrPend_reg;
   logic        phaseOk;
   assign phaseOk = hsel && hready && htrans[1];
   always_ff @(posedge core_clk) begin
      if (srst) begin
         wrPend_reg   <= 1'b0;
         rdPend_reg   <= 1'b0;
         addrPend_reg <= 8'h00;
      end else if (clkEn) begin
         wrPend_reg   <= phaseOk && hwrite;
         rdPend_reg   <= phaseOk && !hwrite;
         if (phaseOk) begin
            addrPend_reg <= haddr[7:0];
         end
      end
   end
   assign hreadyout = 1'b1;  // Zero wait states
   assign hresp     = 1'b0;  // Always OKAY

   function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
      hit = (a[7:2] == o[7:2]);
   endfunction

   logic wrTpafc;
   logic wrRxblen;
   logic wrMacctl;
   logic wrEvstat;
   logic wrTestmd;
   assign wrTpafc  = wrPend_reg && hit(addrPend_reg, rmc_pkg::OFF_TPAFC);
   assign wrRxblen = wrPend_reg && hit(addrPend_reg, rmc_pkg::OFF_RXBLEN);
   assign wrMacctl = wrPend_reg && hit(addrPend_reg, rmc_pkg::OFF_MACCTL);
   assign wrEvstat = wrPend_reg && hit(addrPend_reg, rmc_pkg::OFF_EVSTAT);
   assign wrTestmd = wrPend_reg && hit(addrPend_reg, rmc_pkg::OFF_TESTMD);

   // ==========================================================
   // Soft reset counter
   logic [7:0] srstCnt_reg;
   logic       softRst;
   assign softRst = (srstCnt_reg != 8'h00);
   always_ff @(posedge core_clk) begin
      if (srst) begin
         srstCnt_reg <= 8'h00;
      end else if (clkEn) begin
         if (softRst) begin
            srstCnt_reg <= srstCnt_reg - 8'h01;
         end else if (wrMacctl && hwdata[31]) begin
            srstCnt_reg <= rmc_pkg::SRST_CNT;
         end
      end
   end
   assign macInReset = softRst;

   // ==========================================================
   // Configuration registers
   logic [31:0] tpafc_reg;
   logic [31:0] rxblen_reg;
   logic [31:0] macctl_reg;
   logic [31:0] testmd_reg;
   always_ff @(posedge core_clk) begin
      if (srst) begin
         tpafc_reg  <= rmc_pkg::RST_TPAFC;
         rxblen_reg <= rmc_pkg::RST_RXBLEN;
      end else if (clkEn) begin
         if (softRst) begin
            tpafc_reg  <= rmc_pkg::RST_TPAFC;
            rxblen_reg <= rmc_pkg::RST_RXBLEN;
         end else begin
            if (wrTpafc) begin
               tpafc_reg <= hwdata & rmc_pkg::MSK_TPAFC;
            end
            if (wrRxblen) begin
               rxblen_reg <= hwdata & rmc_pkg::MSK_RXBLEN;
            end
         end
      end
   end

   // Control register; speed, gigabit and loopback survive soft reset
   always_ff @(posedge core_clk) begin
      if (srst) begin
         macctl_reg <= rmc_pkg::RST_MACCTL;
      end else if (clkEn) begin
         if (softRst) begin
            macctl_reg <= macctl_reg & rmc_pkg::MSK_KEEP;
         end else if (wrMacctl) begin
            macctl_reg <= hwdata & rmc_pkg::MSK_MACCTL;
         end
      end
   end
   // Test register
   always_ff @(posedge core_clk) begin
      if (srst) begin
         testmd_reg <= 32'h00000000;
      end else if (clkEn && !softRst && wrTestmd) begin
         testmd_reg <= hwdata & rmc_pkg::MSK_TESTMD;
      end
   end
   assign pollTimerTest = testmd_reg[20];
   assign irqTimerTest  = testmd_reg[19];

   // Decoded control fields
   always_comb begin
      ctl.gigabit             = macctl_reg[9];
      ctl.speed100            = macctl_reg[19];
      ctl.dropBadFcs          = macctl_reg[18];
      ctl.acceptBroadcast     = macctl_reg[17];
      ctl.acceptAllGroup      = macctl_reg[16];
      ctl.acceptHashedGroup   = macctl_reg[15];
      ctl.promiscuousAccept   = macctl_reg[14];
      ctl.oversizeLimitSelect = macctl_reg[13];
      ctl.acceptShort         = macctl_reg[12];
      ctl.appendFcs           = macctl_reg[10];
      ctl.fullDuplex          = macctl_reg[8];
      ctl.receiveDuringSend   = macctl_reg[7];
      ctl.loopback            = macctl_reg[6];
      ctl.urgentRingEnable    = macctl_reg[5];
      ctl.stripTagEnable      = macctl_reg[4];
      ctl.receiverEnable      = macctl_reg[3] && !softRst;
      ctl.transmitterEnable   = macctl_reg[2] && !softRst;
      ctl.receiveDmaEnable    = macctl_reg[1] && !softRst;
      ctl.transmitDmaEnable   = macctl_reg[0] && !softRst;
   end
   assign txCapCode    = tpafc_reg[29:27];
   assign rxCapCode    = tpafc_reg[26:24];
   assign rxDescBufLen = rxblen_reg[13:0];

   // ==========================================================
   // Early thresholds
   logic [15:0] sendThr;
   logic [15:0] drainThr;
   assign sendThr  = {2'b00, tpafc_reg[23:16], 6'h00};
   assign drainThr = {2'b00, tpafc_reg[15:8], 6'h00};
   always_comb begin
      sendStart = ctl.transmitterEnable && (txFrameQueued ||
                  (tpafc_reg[23:16] != 8'h00 &&
                   txQueuedBytes >= sendThr));
      drainStart = ctl.receiveDmaEnable && (rxFrameBuffered ||
                   (tpafc_reg[15:8] != 8'h00 &&
                    rxBufBytes >= drainThr));
   end

   // ==========================================================
   // Ring arbitration
   logic [3:0] urgQuota;
   logic [3:0] regQuota;
   assign urgQuota = (tpafc_reg[7:4] == 4'h0) ? 4'h1 : tpafc_reg[7:4];
   assign regQuota = (tpafc_reg[3:0] == 4'h0) ? 4'h1 : tpafc_reg[3:0];
   rmc_pkg::rmc_ring_t ring_reg;
   rmc_pkg::rmc_ring_t ring_next;
   logic [3:0] urgCnt_reg;
   logic [3:0] regCnt_reg;
   logic       urgOk;
   assign urgOk = ctl.urgentRingEnable && urgentPending;
   always_comb begin
      ring_next = ring_reg;
      case (ring_reg)
         rmc_pkg::RMC_RING_URG: begin
            if (!urgOk || (urgCnt_reg >= urgQuota && regularPending)) begin
               ring_next = rmc_pkg::RMC_RING_REG;
            end
         end
         default: begin
            if (urgOk && (!regularPending ||
                (frameMoved && urgCnt_reg < urgQuota) ||
                regCnt_reg >= regQuota)) begin
               ring_next = rmc_pkg::RMC_RING_URG;
            end
         end
      endcase
   end
   always_ff @(posedge core_clk) begin
      if (srst) begin
         ring_reg   <= rmc_pkg::RMC_RING_REG;
         urgCnt_reg <= 4'h0;
         regCnt_reg <= 4'h0;
      end else if (clkEn) begin
         if (softRst || !ctl.transmitDmaEnable) begin
            ring_reg   <= rmc_pkg::RMC_RING_REG;
            urgCnt_reg <= 4'h0;
            regCnt_reg <= 4'h0;
         end else begin
            ring_reg <= ring_next;
            if (ring_next != ring_reg) begin
               urgCnt_reg <= 4'h0;
               regCnt_reg <= 4'h0;
            end else if (frameMoved && ring_reg == rmc_pkg::RMC_RING_URG) begin
               urgCnt_reg <= (urgCnt_reg == 4'hf) ? urgCnt_reg
                             : urgCnt_reg + 4'h1;
            end else if (frameMoved) begin
               regCnt_reg <= (regCnt_reg == 4'hf) ? regCnt_reg
                             : regCnt_reg + 4'h1;
            end
         end
      end
   end
   assign urgentSelect = (ring_reg == rmc_pkg::RMC_RING_URG);

   // ==========================================================
   // Frame length and address policy
   logic [15:0] longLimit;
   always_comb begin
      if (ctl.oversizeLimitSelect) begin
         longLimit = rxTagged ? rmc_pkg::LEN_JMBTAG : rmc_pkg::LEN_JMB;
      end else begin
         longLimit = rxTagged ? rmc_pkg::LEN_STDTAG : rmc_pkg::LEN_STD;
      end
      rxTooLong    = rxFrameLen > longLimit;
      rxLengthKeep = !rxTooLong && ((rxFrameLen >= rmc_pkg::LEN_MIN) ||
                     (ctl.acceptShort &&
                      rxFrameLen >= rmc_pkg::LEN_RUNTLO));
      rxAddrAccept = ctl.promiscuousAccept ||
                     (rxBroadcast && ctl.acceptBroadcast) ||
                     (!rxBroadcast && rxGroup &&
                      (ctl.acceptAllGroup ||
                       (ctl.acceptHashedGroup && rxHashHit))) ||
                     (!rxGroup && !rxBroadcast && rxUnicastHit);
      rxAllowed = ctl.receiverEnable && (ctl.fullDuplex ||
                  !sending || ctl.receiveDuringSend);
   end

   // ==========================================================
   // Event flags, set wins over write-one clear
   logic [EV_W-1:0] ev_reg;
   genvar gi;
   generate
      for (gi = 0; gi < EV_W; gi++) begin : g_ev
         always_ff @(posedge core_clk) begin
            if (srst) begin
               ev_reg[gi] <= 1'b0;
            end else if (clkEn) begin
               if (evPulse[gi]) begin
                  ev_reg[gi] <= 1'b1;
               end else if (wrEvstat && hwdata[gi]) begin
                  ev_reg[gi] <= 1'b0;
               end
            end
         end
      end
   endgenerate

   // ==========================================================
   // Read data, if/else decode
   always_ff @(posedge core_clk) begin
      if (srst) begin
         hrdata <= 32'h00000000;
      end else if (clkEn) begin
         if (phaseOk && !hwrite) begin
            if (hit(haddr[7:0], rmc_pkg::OFF_TPAFC)) begin
               hrdata <= tpafc_reg;
            end else if (hit(haddr[7:0], rmc_pkg::OFF_RXBLEN)) begin
               hrdata <= rxblen_reg;
            end else if (hit(haddr[7:0], rmc_pkg::OFF_MACCTL)) begin
               hrdata <= {softRst, macctl_reg[30:0]};
            end else if (hit(haddr[7:0], rmc_pkg::OFF_EVSTAT)) begin
               hrdata <= {20'h00000, ev_reg};
            end else if (hit(haddr[7:0], rmc_pkg::OFF_TESTMD)) begin
               hrdata <= testmd_reg;
            end else if (hit(haddr[7:0], rmc_pkg::OFF_FEATURE)) begin
               hrdata <= {26'h0000000, rmc_pkg::REAL_TXCAP,
                          rmc_pkg::REAL_RXCAP};
            end else begin
               hrdata <= 32'h00000000;
            end
         end
      end
   end

   // ==========================================================
   // Checks
   AST_SRST_LEN: assert property (@(posedge core_clk) disable iff (srst)
      ($rose(softRst) && clkEn) ##1 clkEn[*7] |-> softRst)
      else $error("soft reset ended early");
   AST_SRST_START: assert property (@(posedge core_clk) disable iff (srst)
      clkEn && wrMacctl && hwdata[31] && !softRst |=> softRst)
      else $error("soft reset did not start");
   AST_KEEP_SPEED: assert property (@(posedge core_clk) disable iff (srst)
      softRst && clkEn |=> $stable(macctl_reg[19]))
      else $error("speed bit lost in soft reset");
   AST_FLAG_HOLD: assert property (@(posedge core_clk) disable iff (srst)
      clkEn && evPulse[8] |=> ev_reg[8])
      else $error("event flag lost");
   AST_FLAG_CLR: assert property (@(posedge core_clk) disable iff (srst)
      clkEn && wrEvstat && hwdata[0] && !evPulse[0] |=> !ev_reg[0])
      else $error("flag not cleared");
   AST_SEND_ZERO: assert property (@(posedge core_clk) disable iff (srst)
      tpafc_reg[23:16] == 8'h00 && !txFrameQueued |-> !sendStart)
      else $error("send started without whole frame");
   AST_DRAIN: assert property (@(posedge core_clk) disable iff (srst)
      ctl.receiveDmaEnable && rxFrameBuffered |-> drainStart)
      else $error("drain not started");
   AST_LONG: assert property (@(posedge core_clk) disable iff (srst)
      !ctl.oversizeLimitSelect && !rxTagged && rxFrameLen == 16'h05ef
      |-> rxTooLong)
      else $error("oversize missed");
   AST_RUNT: assert property (@(posedge core_clk) disable iff (srst)
      rxFrameLen < 16'h000a |-> !rxLengthKeep)
      else $error("tiny frame kept");
   AST_URG_ONLY: assert property (@(posedge core_clk) disable iff (srst)
      clkEn && ctl.transmitDmaEnable && urgOk && !regularPending
      |=> urgentSelect)
      else $error("urgent ring not served");
   COV_SRST: cover property (@(posedge core_clk) $fell(softRst));
   COV_URG: cover property (@(posedge core_clk) $rose(urgentSelect));
   COV_CLR_SET: cover property (@(posedge core_clk)
      wrEvstat && hwdata[8] && evPulse[8]);
endmodule
`default_nettype wire

/* File: rmc_mac_ctl_bench.sv */
// Testbench for the MAC control block: bus tasks, one task a scenario.
// Assumes the partner model raises the event strobes on request.
`default_nettype none
module rmc_mac_ctl_bench;
   timeunit 1ns;
   timeprecision 1ns;
   logic        core_clk, srst, hsel, hwrite, fire, txFrameQueued, rxTagged;
   logic        rxFrameBuffered, rxBroadcast, urgentPending, regularPending;
   logic        hreadyout, sendStart, drainStart, rxTooLong, rxAddrAccept;
   logic        macInReset, pollTimerTest, urgentSelect;
   logic        rxGroup, rxLengthKeep, irqTimerTest;
   logic [13:0] rxDescBufLen;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0]  htrans;
   logic [2:0]  hsize, txCapCode, rxCapCode;
   logic [3:0]  idx;
   logic [11:0] evPulse;
   logic [15:0] txQueuedBytes, rxBufBytes, rxFrameLen;
   int          errorCnt, numChecks, n;
   // ====================================================
   // Block and partner
   rmc_mac_ctl u_rmc_mac_ctl (.core_clk(core_clk), .srst(srst), .clkEn(1'b1),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(), .evPulse(evPulse),
      .txQueuedBytes(txQueuedBytes), .txFrameQueued(txFrameQueued),
      .rxBufBytes(rxBufBytes), .rxFrameBuffered(rxFrameBuffered),
      .urgentPending(urgentPending), .regularPending(regularPending),
      .frameMoved(1'b0), .rxFrameLen(rxFrameLen), .rxTagged(rxTagged),
      .rxBroadcast(rxBroadcast), .rxGroup(rxGroup), .rxHashHit(1'b0),
      .rxUnicastHit(1'b0), .sending(1'b0), .sendStart(sendStart),
      .drainStart(drainStart), .urgentSelect(urgentSelect),
      .rxTooLong(rxTooLong), .rxLengthKeep(rxLengthKeep),
      .rxAddrAccept(rxAddrAccept), .rxAllowed(), .macInReset(macInReset),
      .ctl(), .txCapCode(txCapCode), .rxCapCode(rxCapCode),
      .rxDescBufLen(rxDescBufLen), .pollTimerTest(pollTimerTest),
      .irqTimerTest(irqTimerTest));
   rmc_dp_model u_rmc_dp_model (.core_clk(core_clk), .fire(fire),
      .idx(idx), .evPulse(evPulse));
   // ====================================================
   // Compare, bus transfer and verdict
   task automatic chk(input logic [31:0] got, exp);
      numChecks++;
      if (got !== exp) begin
         errorCnt++;
         $display("wrong value at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic wr, input logic [7:0] a,
                      input logic [31:0] wd);
      @(posedge core_clk);
      {hsel, htrans, hwrite, hsize, haddr} <= {3'b110, wr, 3'h2, 24'h0, a};
      do @(posedge core_clk); while (hreadyout !== 1'b1);
      {hsel, htrans, hwdata} <= {3'b000, wd};
      do @(posedge core_clk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask
   task automatic tally_and_finish();
      $display("errors %0d checks %0d", errorCnt, numChecks);
      if (errorCnt == 0 && numChecks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // ====================================================
   // Scenarios
   task automatic t_regs();
      rdchk(8'h48, 32'h000000f1);
      rdchk(8'h44, {26'h0, rmc_pkg::REAL_TXCAP, rmc_pkg::REAL_RXCAP});
      rdchk(8'h4c, 32'h00000640);
      rdchk(8'h54, 32'h00000000);
      bus(1'b1, 8'h4c, 32'h00000600);
      rdchk(8'h4c, 32'h00000600);
      chk({18'h0, rxDescBufLen}, 32'h600);
      bus(1'b1, 8'h58, 32'h00180000);
      rdchk(8'h58, 32'h00180000);
      chk({30'h0, pollTimerTest, irqTimerTest}, 32'h3);
   endtask
   task automatic t_events();
      for (int i = 0; i < 12; i++) begin
         fire <= 1'b1;
         idx <= 4'(i);
         @(posedge core_clk);
         fire <= 1'b0;
         rdchk(8'h54, 32'h1 << i);
         bus(1'b1, 8'h54, 32'h1 << i);
         rdchk(8'h54, 32'h0);
      end
      fork
         bus(1'b1, 8'h54, 32'h00000100);
         begin
            @(posedge core_clk);
            {fire, idx} <= 5'h18;
            @(posedge core_clk);
            fire <= 1'b0;
         end
      join
      rdchk(8'h54, 32'h00000100);
   endtask
   task automatic lv(input logic [15:0] tq, rb, input logic tf, rf,
                     input logic [1:0] exp);
      @(posedge core_clk);
      {txQueuedBytes, rxBufBytes, txFrameQueued, rxFrameBuffered} <=
         {tq, rb, tf, rf};
      #10;
      chk({30'h0, sendStart, drainStart}, {30'h0, exp});
   endtask
   task automatic t_thresh();
      bus(1'b1, 8'h48, 32'h09020311);
      bus(1'b1, 8'h50, 32'h00000006);
      chk({29'h0, txCapCode}, 32'h1);
      chk({29'h0, rxCapCode}, 32'h1);
      lv(16'd127, 16'd191, 1'b0, 1'b0, 2'b00);
      lv(16'd128, 16'd192, 1'b0, 1'b0, 2'b11);
      lv(16'd0, 16'd0, 1'b1, 1'b1, 2'b11);
      bus(1'b1, 8'h48, 32'h09000011);
      lv(16'd4000, 16'd4000, 1'b0, 1'b0, 2'b00);
      lv(16'd4000, 16'd4000, 1'b1, 1'b1, 2'b11);
      bus(1'b1, 8'h50, 32'h00000021);
      {urgentPending, regularPending} <= 2'b10;
      n = 0;
      while (urgentSelect !== 1'b1 && n < 20) begin
         @(posedge core_clk);
         n++;
      end
      chk({31'h0, urgentSelect}, 32'h1);
   endtask
   task automatic t_length();
      for (int j = 0; j < 2; j++) begin
         bus(1'b1, 8'h50, {14'h0, j[0], 3'h0, j[0], 13'h0});
         for (int k = 0; k < 4; k++) begin
            rxTagged <= k[1];
            rxBroadcast <= 1'b1;
            rxFrameLen <= 16'((j ? 9216 : 1518) + 4 * k[1] + k[0]);
            @(posedge core_clk);
            #10;
            chk({31'h0, rxTooLong}, {31'h0, k[0]});
            chk({31'h0, rxLengthKeep}, {31'h0, !k[0]});
            chk({31'h0, rxAddrAccept}, {31'h0, j[0]});
         end
      end
      {rxBroadcast, rxGroup} <= 2'b01;
      #10;
      chk({31'h0, rxAddrAccept}, 32'h0);
      bus(1'b1, 8'h50, 32'h00010000);
      #10;
      chk({31'h0, rxAddrAccept}, 32'h1);
   endtask
   task automatic t_softrst();
      bus(1'b1, 8'h50, 32'h8008004f);
      #10;
      n = 0;
      while (macInReset === 1'b1 && n < 400) begin
         @(posedge core_clk);
         #10;
         n++;
      end
      chk(n, 32'd175);
      rdchk(8'h50, 32'h00080040);
      rdchk(8'h48, 32'h000000f1);
   endtask
   // ====================================================
   // Clock, reset, sequence and watchdog
   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end
   initial begin
      {hsel, htrans, hwrite, hsize, haddr, hwdata, fire, idx} = '0;
      {txQueuedBytes, rxBufBytes, rxFrameLen, txFrameQueued} = '0;
      {rxFrameBuffered, rxTagged, rxBroadcast, rxGroup} = '0;
      {urgentPending, regularPending} = '0;
      {errorCnt, numChecks} = '0;
      srst = 1'b1;
      repeat (6) @(posedge core_clk);
      srst <= 1'b0;
      t_regs();
      t_events();
      t_thresh();
      t_length();
      t_softrst();
      tally_and_finish();
   end
   initial begin
      #3000000;
      errorCnt++;
      tally_and_finish();
   end
endmodule
`default_nettype wire

/* File: rmc_pkg.sv */
// Package for the MAC control and status block: offsets, fields, resets.
// Assumes a 32-bit AHB-Lite register bus on a 10 MHz core clock.
`default_nettype none
package rmc_pkg;
   // ==========================================================
   // Register byte offsets
   localparam logic [7:0] OFF_TPAFC   = 8'h48;
   localparam logic [7:0] OFF_RXBLEN  = 8'h4c;
   localparam logic [7:0] OFF_MACCTL  = 8'h50;
   localparam logic [7:0] OFF_EVSTAT  = 8'h54;
   localparam logic [7:0] OFF_TESTMD  = 8'h58;
   localparam logic [7:0] OFF_FEATURE = 8'h44;
   // ==========================================================
   // Reset values
   localparam logic [31:0] RST_TPAFC  = 32'h000000f1;
   localparam logic [31:0] RST_RXBLEN = 32'h00000640;
   localparam logic [31:0] RST_MACCTL = 32'h00000000;
   // Writable masks, soft reset keep mask and event flag count
   localparam logic [31:0] MSK_TPAFC  = 32'h3fffffff;
   localparam logic [31:0] MSK_RXBLEN = 32'h00003fff;
   localparam logic [31:0] MSK_MACCTL = 32'h800ff7ff;
   localparam logic [31:0] MSK_TESTMD = 32'h00180000;
   localparam logic [31:0] MSK_KEEP   = 32'h00080240;
   localparam int          EV_BITS    = 12;
   // ==========================================================
   // Capacity codes and limits
   localparam logic [2:0]  CAP_MAX    = 3'h4;
   localparam logic [2:0]  REAL_TXCAP = 3'h2;
   localparam logic [2:0]  REAL_RXCAP = 3'h2;
   localparam logic [15:0] LEN_STD    = 16'h05ee;
   localparam logic [15:0] LEN_STDTAG = 16'h05f2;
   localparam logic [15:0] LEN_JMB    = 16'h2400;
   localparam logic [15:0] LEN_JMBTAG = 16'h2404;
   localparam logic [15:0] LEN_MIN    = 16'h0040;
   localparam logic [15:0] LEN_RUNTLO = 16'h000a;
   localparam int          UNIT_SHIFT = 6;
   // ==========================================================
   // Soft reset time
   localparam int CLK_HZ        = 10000000;
   localparam int SRST_CYCLES   = 175;
   localparam logic [7:0] SRST_CNT = 8'(SRST_CYCLES);
   // Ring selection states
   typedef enum logic [1:0] {
      RMC_RING_REG = 2'b00,
      RMC_RING_URG = 2'b01
   } rmc_ring_t;
   // Control fields decoded from registers
   typedef struct packed {
      logic       gigabit;
      logic       speed100;
      logic       dropBadFcs;
      logic       acceptBroadcast;
      logic       acceptAllGroup;
      logic       acceptHashedGroup;
      logic       promiscuousAccept;
      logic       oversizeLimitSelect;
      logic       acceptShort;
      logic       appendFcs;
      logic       fullDuplex;
      logic       receiveDuringSend;
      logic       loopback;
      logic       urgentRingEnable;
      logic       stripTagEnable;
      logic       receiverEnable;
      logic       transmitterEnable;
      logic       receiveDmaEnable;
      logic       transmitDmaEnable;
   } rmc_ctl_t;
endpackage
`default_nettype wire
